// ==== design/alarm_pkg.sv ====
// Package with constants and types for the load alarm supervisor.
package alarm_pkg;

	// Alarm type indices, also status bit positions.
	localparam int ALARM_COUNT = 6;
	localparam int IDX_SUPPLY = 0;
	localparam int IDX_OVERHEAT = 1;
	localparam int IDX_OVERVOLT = 2;
	localparam int IDX_OVERCURRENT = 3;
	localparam int IDX_OVERPOWER = 4;
	localparam int IDX_SHARING = 5;

	// Register byte offsets.
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_ACK = 12'h008;
	localparam logic [11:0] OFS_OVP_LIMIT = 12'h00C;
	localparam logic [11:0] OFS_OCP_LIMIT = 12'h010;
	localparam logic [11:0] OFS_OPP_LIMIT = 12'h014;
	localparam logic [11:0] OFS_COUNT_BASE = 12'h020;

	// Control register fields.
	localparam int CTRL_INPUT_ON = 0;
	localparam int CTRL_PF_AUTO = 1;
	localparam int CTRL_OT_AUTO = 2;
	localparam int CTRL_MS_LO = 3;
	localparam int CTRL_MS_HI = 4;
	localparam int CTRL_MS_INIT = 5;
	localparam int CTRL_ANALOG_LO = 8;
	localparam int CTRL_ANALOG_HI = 13;

	// Reset values.
	localparam logic [5:0] ANALOG_MASK_RESET = 6'h06;
	localparam logic [15:0] OVP_LIMIT_RESET = 16'hFFFF;
	localparam logic [15:0] OCP_LIMIT_RESET = 16'hFFFF;
	localparam logic [31:0] OPP_LIMIT_RESET = 32'hFFFFFFFF;

	// Largest overvoltage threshold in percent of nominal.
	localparam int OVP_MAX_PERCENT = 110;

	// Master-slave role.
	typedef enum logic [1:0] {
		ROLE_OFF,
		ROLE_MASTER,
		ROLE_SLAVE,
		ROLE_RESERVED
	} ms_role_t;

endpackage

// ==== design/load_alarm_supervisor.sv ====
// Alarm supervision block of a programmable DC load with an APB register port.
//
// What this block does
// - Report alarms on indicator, status and analog.
// - Analog error defaults to overheat and overvoltage.
// - Specific alarm cause visible only in status.
// - Per-alarm occurrence counters, readable after clearing.
// - Supply fail switches the DC input off.
// - Supply-fail auto restart optional; default stays off.
// - Every power-down raises a supply-fail alarm.
// - Overheat switches input off while too hot.
// - Overheat auto restart after cooling is configurable.
// - Overvoltage above programmed threshold switches off.
// - Overcurrent at limit switches input off.
// - Overpower at limit switches input off.
// - Sharing fail blocks switch-on, trips running input.
// - No mode, no cable: no sharing fail.
// - No mode, cable connected: sharing fail.
// - Master flags slave failures seen at initialization.
// - Disconnected slave: uncleared sharing fail, reported out.
// - Slave initialized late signals sharing fail.
// - Cable break after initialization raises sharing fail.
// - Alarms stay latched until acknowledged.
// - Front button acknowledges latched alarms.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ns

module load_alarm_supervisor
	import alarm_pkg::*;
#(
	parameter int VW = 16,
	parameter int CW = 16,
	parameter int OVP_NOMINAL = 1000
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Condition pins from the power stage, sharing link and front button, asynchronous.
	input wire logic mains_low,
	input wire logic input_stage_fault,
	input wire logic overheat_in,
	input wire logic share_cable_present,
	input wire logic share_slave_fail,
	input wire logic button_ack,
	// Measurement samples, same clock.
	input wire logic sample_valid,
	input wire logic [VW-1:0] meas_voltage,
	input wire logic [CW-1:0] meas_current,
	// Outputs.
	output logic dc_input_enable,
	output logic error_led,
	output logic analog_error,
	output logic share_fail_report
);

	// Elaboration check: the overvoltage and overcurrent limit registers hold 16 bits, so wider samples
	// would be cut silently; a zero nominal voltage gives no usable ceiling.
	if (VW < 1 || VW > 16 || CW < 1 || CW > 16 || OVP_NOMINAL < 1) begin : g_bad_params
		$error("load_alarm_supervisor: unsupported parameter values");
	end

	localparam logic [31:0] OVP_CEIL = 32'((OVP_NOMINAL * OVP_MAX_PERCENT) / 100);

	// Two-stage synchronisers for pin inputs.
	logic [5:0] pin_meta_reg;
	logic [5:0] pin_sync_reg;
	logic button_prev_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_reg <= 6'h00;
			pin_sync_reg <= 6'h00;
		end else begin
			pin_meta_reg <= {button_ack, share_slave_fail, share_cable_present,
				overheat_in, input_stage_fault, mains_low};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// Named synchronised conditions.
	wire supply_bad = pin_sync_reg[0] | pin_sync_reg[1];
	wire hot = pin_sync_reg[2];
	wire cable = pin_sync_reg[3];
	wire slave_fail = pin_sync_reg[4];
	wire button_level = pin_sync_reg[5];
	wire button_press = button_level & ~button_prev_reg;

	// Registers written by software, then sharing-link tracking state.
	logic input_on_reg;
	logic pf_auto_reg;
	logic ot_auto_reg;
	ms_role_t role_reg;
	logic ms_init_reg;
	logic [5:0] analog_mask_reg;
	logic [15:0] ovp_limit_reg;
	logic [15:0] ocp_limit_reg;
	logic [31:0] opp_limit_reg;
	logic ms_init_seen_reg;
	logic ms_init_late_reg;
	logic booting_reg;
	logic cable_seen_reg;

	// APB decode.
	wire write_access = psel & penable & pwrite;
	wire read_phase = psel & ~pwrite;
	wire hit_ctrl = paddr == OFS_CTRL;
	wire hit_status = paddr == OFS_STATUS;
	wire hit_ack = paddr == OFS_ACK;
	wire hit_ovp = paddr == OFS_OVP_LIMIT;
	wire hit_ocp = paddr == OFS_OCP_LIMIT;
	wire hit_opp = paddr == OFS_OPP_LIMIT;
	wire [11:0] count_rel = paddr - OFS_COUNT_BASE;
	wire hit_count = paddr >= OFS_COUNT_BASE && count_rel[11:2] < 10'(ALARM_COUNT)
		&& paddr[1:0] == 2'b00;
	wire mapped = hit_ctrl | hit_status | hit_ack | hit_ovp | hit_ocp | hit_opp | hit_count;
	wire [31:0] ovp_write_val = {16'h0000, pwdata[15:0]};
	wire ovp_write_ok = ovp_write_val <= OVP_CEIL;
	wire ack_write = write_access & hit_ack;
	// Every access completes in its first access cycle, with no wait state.
	assign pready = 1'b1;
	// Writes of an over-range threshold are refused with an error.
	assign pslverr = psel & penable & (~mapped | (pwrite & hit_ovp & ~ovp_write_ok));

	// Byte-lane merge, shared by the control and limit registers.
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			old[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
		return old;
	endfunction

	wire [31:0] ctrl_now = {18'h00000, analog_mask_reg, 2'b00, ms_init_reg, role_reg,
		ot_auto_reg, pf_auto_reg, input_on_reg};
	wire [31:0] ctrl_new = lane_merge(ctrl_now, pwdata, pstrb);

	// Control register writes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_on_reg <= 1'b0;
			pf_auto_reg <= 1'b0;
			ot_auto_reg <= 1'b0;
			role_reg <= ROLE_OFF;
			ms_init_reg <= 1'b0;
			analog_mask_reg <= ANALOG_MASK_RESET;
		end else if (write_access & hit_ctrl) begin
			input_on_reg <= ctrl_new[CTRL_INPUT_ON];
			pf_auto_reg <= ctrl_new[CTRL_PF_AUTO];
			ot_auto_reg <= ctrl_new[CTRL_OT_AUTO];
			role_reg <= ms_role_t'(ctrl_new[CTRL_MS_HI:CTRL_MS_LO]);
			ms_init_reg <= ctrl_new[CTRL_MS_INIT];
			analog_mask_reg <= ctrl_new[CTRL_ANALOG_HI:CTRL_ANALOG_LO];
		end
	end

	// Merged limit values; lanes without a strobe keep their old contents.
	wire [31:0] ovp_merged = lane_merge({16'h0000, ovp_limit_reg}, pwdata, pstrb);
	wire [31:0] ocp_merged = lane_merge({16'h0000, ocp_limit_reg}, pwdata, pstrb);
	wire [31:0] opp_merged = lane_merge(opp_limit_reg, pwdata, pstrb);

	// Limit registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovp_limit_reg <= OVP_LIMIT_RESET;
			ocp_limit_reg <= OCP_LIMIT_RESET;
			opp_limit_reg <= OPP_LIMIT_RESET;
		end else if (write_access) begin
			if (hit_ovp && ovp_write_ok) begin
				ovp_limit_reg <= ovp_merged[15:0];
			end
			if (hit_ocp) begin
				ocp_limit_reg <= ocp_merged[15:0];
			end
			if (hit_opp) begin
				opp_limit_reg <= opp_merged;
			end
		end
	end

	// Limit comparisons on each new sample, acting in the same cycle.
	wire [31:0] power_now = 32'(meas_voltage) * 32'(meas_current);
	wire ovp_hit = sample_valid && 16'(meas_voltage) > ovp_limit_reg;
	wire ocp_hit = sample_valid && 16'(meas_current) >= ocp_limit_reg;
	wire opp_hit = sample_valid && power_now >= opp_limit_reg;

	// Initialization tracking for the sharing link. Boot lasts until first
	// sample after reset, which stands in for the end of power-up.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_init_seen_reg <= 1'b0;
			ms_init_late_reg <= 1'b0;
			booting_reg <= 1'b1;
			button_prev_reg <= 1'b0;
			cable_seen_reg <= 1'b0;
		end else begin
			button_prev_reg <= button_level;
			if (sample_valid) begin
				booting_reg <= 1'b0;
			end
			if (ms_init_reg && !ms_init_seen_reg) begin
				ms_init_seen_reg <= 1'b1;
				ms_init_late_reg <= ~booting_reg;
			end
			// A master remembers that the link was up, so that a later loss
			// reads as a cable break and not as a master left unconnected.
			if (role_reg == ROLE_MASTER && ms_init_seen_reg && cable) begin
				cable_seen_reg <= 1'b1;
			end
			if (!ms_init_reg) begin
				ms_init_seen_reg <= 1'b0;
				cable_seen_reg <= 1'b0;
				ms_init_late_reg <= 1'b0;
			end
		end
	end

	// Sharing link fault cause, per role and cable state.
	logic share_cause;
	always_comb begin
		case (role_reg)
			ROLE_OFF: share_cause = cable;
			ROLE_MASTER: share_cause = ms_init_seen_reg & slave_fail;
			ROLE_SLAVE: share_cause = ~cable
				| (ms_init_seen_reg & ms_init_late_reg)
				| (ms_init_seen_reg & ~cable);
			default: share_cause = 1'b0;
		endcase
	end
	// A master that never saw the link raises no cable break; only a loss after it was up trips.
	wire master_cable_break = role_reg == ROLE_MASTER && cable_seen_reg && !cable;
	wire slave_sticky = role_reg == ROLE_SLAVE && !cable;

	// Present causes per alarm type; supply fail covers power-down too.
	wire [5:0] cause = {share_cause | master_cable_break, opp_hit, ocp_hit, ovp_hit, hot,
		supply_bad};

	// Latched alarms: set wins over clear; clear only once the cause is gone.
	logic [5:0] latched_reg;
	wire ack_any = button_press | ack_write;
	wire [5:0] ack_bits = button_press ? 6'h3F : (ack_write ? pwdata[5:0] : 6'h00);
	wire [5:0] clear_ok = ack_bits & ~cause & ~{slave_sticky, 5'h00};
	// An occurrence is a cause that finds its alarm not yet latched; a limit
	// held across many samples pulses on each one but counts only once.
	wire [5:0] rise = cause & ~latched_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latched_reg <= 6'h00;
		end else begin
			latched_reg <= (latched_reg & ~clear_ok) | cause;
		end
	end

	// Occurrence counters, one per alarm type.
	logic [15:0] count_reg [ALARM_COUNT];
	genvar g;
	generate
		for (g = 0; g < ALARM_COUNT; g++) begin : g_count
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					count_reg[g] <= 16'h0000;
				end else if (rise[g] && count_reg[g] != 16'hFFFF) begin
					count_reg[g] <= count_reg[g] + 16'h0001;
				end
			end
		end
	endgenerate

	// Auto restart state: an input tripped by supply or heat waits for the
	// cause to clear, then resumes if the matching auto setting is on or once acknowledged.
	// An acknowledge drops the sources first; the restart test passes a cycle later.
	logic tripped_reg;
	logic [5:0] trip_src_reg;
	wire restart_ok = (!trip_src_reg[IDX_SUPPLY] || (pf_auto_reg && !supply_bad))
		&& (!trip_src_reg[IDX_OVERHEAT] || (ot_auto_reg && !hot))
		&& trip_src_reg[5:2] == 4'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tripped_reg <= 1'b0;
			trip_src_reg <= 6'h00;
		end else if (|cause) begin
			tripped_reg <= 1'b1;
			trip_src_reg <= trip_src_reg | cause;
		end else if (tripped_reg && (restart_ok || (ack_any && latched_reg == 6'h00))) begin
			tripped_reg <= 1'b0;
			trip_src_reg <= 6'h00;
		end else if (ack_any) begin
			trip_src_reg <= trip_src_reg & ~clear_ok;
		end
	end

	// Input enable: cut combinationally the same cycle a cause appears.
	// Sharing fail also blocks switch-on while it stays latched.
	assign dc_input_enable = input_on_reg & ~tripped_reg & ~(|cause)
		& ~latched_reg[IDX_SHARING];

	// Indications: front LED, analog collective, sharing report to master.
	logic error_led_reg;
	logic analog_error_reg;
	logic share_report_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			error_led_reg <= 1'b0;
			analog_error_reg <= 1'b0;
			share_report_reg <= 1'b0;
		end else begin
			error_led_reg <= |latched_reg;
			analog_error_reg <= |(latched_reg & analog_mask_reg);
			share_report_reg <= role_reg == ROLE_SLAVE && latched_reg[IDX_SHARING];
		end
	end
	assign error_led = error_led_reg;
	assign analog_error = analog_error_reg;
	assign share_fail_report = share_report_reg;

	// Read data mux; status shows the specific alarm, the analog line never does.
	// The counter index is forced to zero off the counter range, so the array
	// is never indexed past its end when another register is read.
	wire [2:0] count_idx = hit_count ? count_rel[4:2] : 3'h0;
	wire [31:0] read_val = hit_ctrl ? ctrl_now
		: hit_status ? {14'h0000, 2'(role_reg), ms_init_seen_reg, tripped_reg,
			dc_input_enable, 1'b0, cause, latched_reg}
		: hit_ovp ? {16'h0000, ovp_limit_reg}
		: hit_ocp ? {16'h0000, ocp_limit_reg}
		: hit_opp ? opp_limit_reg
		: hit_count ? {16'h0000, count_reg[count_idx]}
		: 32'h00000000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (read_phase && !penable) begin
			prdata <= read_val;
		end
	end

endmodule // load_alarm_supervisor

// ==== sim/alarm_props.sv ====
// Port-level checker for the load alarm supervisor.
`timescale 1ns/1ns
module alarm_props
	import alarm_pkg::*;
#(
	parameter int OVP_NOMINAL = 1000
) (
	// Clock, reset and APB.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Conditions and outputs.
	input wire logic mains_low,
	input wire logic overheat_in,
	input wire logic button_ack,
	input wire logic sample_valid,
	input wire logic [15:0] meas_current,
	input wire logic dc_input_enable,
	input wire logic error_led
);
	localparam int OVP_CEIL = OVP_NOMINAL * OVP_MAX_PERCENT / 100;
	wire logic acc = psel && penable && pready;
	logic [15:0] ocp_lim_reg;
	logic [7:0] btn_hist_reg;
	// Shadow of the overcurrent limit and a short button history, since the
	// synchroniser delays a button acknowledge by a few cycles.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ocp_lim_reg <= OCP_LIMIT_RESET;
			btn_hist_reg <= 8'h00;
		end else begin
			btn_hist_reg <= {btn_hist_reg[6:0], button_ack};
			if (acc && pwrite && paddr == OFS_OCP_LIMIT && pstrb[1:0] == 2'h3)
				ocp_lim_reg <= pwdata[15:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_no_wait: assert property (psel && penable |-> pready) else $error("apb wait state seen");
	a_unmapped_err: assert property (acc && !pwrite && paddr == 12'h018 |-> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	a_ovp_ceiling: assert property (
		acc && pwrite && paddr == OFS_OVP_LIMIT && pwdata[15:0] > OVP_CEIL |-> pslverr)
		else $error("overvoltage limit above ceiling accepted");
	a_supply_off: assert property (mains_low [*5] |-> !dc_input_enable)
		else $error("input on during supply fail");
	a_heat_off: assert property (overheat_in [*5] |-> !dc_input_enable)
		else $error("input on during overheat");
	a_led_held: assert property (mains_low [*8] |-> error_led)
		else $error("indicator off while cause present");
	a_ocp_trip: assert property (
		sample_valid && meas_current >= ocp_lim_reg |-> !dc_input_enable)
		else $error("input on at overcurrent sample");
	a_led_ack: assert property ($fell(error_led) |->
		$past(acc && pwrite && paddr == OFS_ACK, 2) || btn_hist_reg != 8'h00)
		else $error("indicator cleared without acknowledge");
endmodule // alarm_props

bind load_alarm_supervisor alarm_props #(.OVP_NOMINAL(OVP_NOMINAL)) u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .mains_low(mains_low), .overheat_in(overheat_in),
	.button_ack(button_ack), .sample_valid(sample_valid), .meas_current(meas_current),
	.dc_input_enable(dc_input_enable), .error_led(error_led));

// ==== sim/power_stage_model.sv ====
// Power stage model that delivers measurement samples to the supervisor.
`timescale 1ns/1ns
module power_stage_model (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Levels the stage presents at each sample.
	input wire logic [15:0] set_v,
	input wire logic [15:0] set_i,
	// Sample bus towards the supervisor.
	output logic sample_valid,
	output logic [15:0] meas_voltage,
	output logic [15:0] meas_current
);
	logic [1:0] phase_reg;
	// One sample every fourth cycle; between samples the lines carry the
	// inverse, so a stale value is never mistaken for a fresh one.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= 2'h0;
			sample_valid <= 1'b0;
			meas_voltage <= 16'h0000;
			meas_current <= 16'h0000;
		end else begin
			phase_reg <= phase_reg + 2'h1;
			sample_valid <= phase_reg == 2'h3;
			meas_voltage <= phase_reg == 2'h3 ? set_v : ~set_v;
			meas_current <= phase_reg == 2'h3 ? set_i : ~set_i;
		end
	end
endmodule // power_stage_model

// ==== sim/load_alarm_supervisor_tb.sv ====
// Self-checking bench for the load alarm supervisor.
`timescale 1ns/1ns
module load_alarm_supervisor_tb;
	import alarm_pkg::*;
	localparam int NOM = 1000;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, err_seen, sample_valid, dc_input_enable;
	logic error_led, analog_error, share_fail_report;
	logic [1:0] pf_src = 2'h0;
	logic overheat_in = 1'b0, cable = 1'b0, slave_fail = 1'b0, button_ack = 1'b0;
	logic [15:0] set_v = 16'h0064, set_i = 16'h0000, meas_voltage, meas_current;
	int errors = 0, num_checks = 0, seed = 68, cycles = 0, lat = 0, lim;
	int cnt[6] = '{default: 0};
	load_alarm_supervisor #(.OVP_NOMINAL(NOM)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mains_low(pf_src[0]), .input_stage_fault(pf_src[1]), .overheat_in(overheat_in),
		.share_cable_present(cable), .share_slave_fail(slave_fail), .button_ack(button_ack),
		.sample_valid(sample_valid), .meas_voltage(meas_voltage), .meas_current(meas_current),
		.dc_input_enable(dc_input_enable), .error_led(error_led),
		.analog_error(analog_error), .share_fail_report(share_fail_report));
	power_stage_model stage (.pclk(pclk), .presetn(presetn), .set_v(set_v), .set_i(set_i),
		.sample_valid(sample_valid), .meas_voltage(meas_voltage), .meas_current(meas_current));
	// Clock at 10 MHz.
	initial forever #50 pclk = ~pclk;
	// A hang ends the run as a mismatch.
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (errors == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One APB transfer; the leading edge keeps back-to-back calls from
	// assigning the strobes twice in one time step.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(name, rd, exp);
	endtask
	task automatic settle();
		repeat (12) @(posedge pclk);
	endtask
	task automatic status_is(input int exp);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("status", rd[5:0], exp[5:0]);
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("ctrl", OFS_CTRL, 32'h00000600);
		rdchk("ovp", OFS_OVP_LIMIT, 32'h0000FFFF);
		rdchk("opp", OFS_OPP_LIMIT, 32'hFFFFFFFF);
		apb(1'b0, 12'h018, 32'h0);
		check("unmapped", {err_seen, rd[30:0]}, 32'h80000000);
		apb(1'b1, OFS_OVP_LIMIT, NOM * 110 / 100 + 1);
		check("ovp refuse", err_seen, 1'b1);
		rdchk("ovp kept", OFS_OVP_LIMIT, 32'h0000FFFF);
		apb(1'b1, OFS_OVP_LIMIT, NOM * 110 / 100);
		check("ovp ceiling", err_seen, 1'b0);
		lim = 32'h100 + ($random(seed) & 32'hFF);
		apb(1'b1, OFS_OCP_LIMIT, lim);
		apb(1'b1, OFS_CTRL, 32'h00000601);
		settle();
		check("enable", dc_input_enable, 1'b1);
		status_is(0);
		// Overcurrent exactly at the limit, then just below.
		set_i <= lim[15:0];
		settle();
		cnt[3]++;
		check("ocp off", dc_input_enable, 1'b0);
		check("led", error_led, 1'b1);
		check("analog", analog_error, 1'b0);
		set_i <= lim[15:0] - 16'h0001;
		settle();
		status_is(32'h08);
		apb(1'b1, OFS_ACK, 32'h3F);
		status_is(0);
		settle();
		check("ocp back", dc_input_enable, 1'b1);
		// Both supply fail causes, the second acknowledged by the button.
		for (int k = 0; k < 2; k++) begin
			pf_src[k] <= 1'b1;
			settle();
			cnt[0]++;
			check("pf off", dc_input_enable, 1'b0);
			apb(1'b1, OFS_ACK, 32'h01);
			status_is(32'h01);
			pf_src[k] <= 1'b0;
			settle();
			check("pf stays", dc_input_enable, 1'b0);
			if (k == 0) apb(1'b1, OFS_ACK, 32'h01);
			else button_ack <= 1'b1;
			settle();
			button_ack <= 1'b0;
			check("pf led", error_led, 1'b0);
			check("pf back", dc_input_enable, 1'b1);
		end
		// Overheat with automatic restart.
		apb(1'b1, OFS_CTRL, 32'h00000605);
		overheat_in <= 1'b1;
		settle();
		cnt[1]++;
		check("ot off", dc_input_enable, 1'b0);
		check("ot analog", analog_error, 1'b1);
		overheat_in <= 1'b0;
		settle();
		check("ot auto", dc_input_enable, 1'b1);
		check("ot led", error_led, 1'b1);
		apb(1'b1, OFS_ACK, 32'h3F);
		// Overvoltage above its threshold, then overpower exactly at its limit.
		for (int k = 0; k < 2; k++) begin
			if (k == 1) apb(1'b1, OFS_OPP_LIMIT, 101 * (lim - 1));
			set_v <= k ? 16'h0065 : 16'h044D;
			settle();
			cnt[k ? 4 : 2]++;
			check("limit off", dc_input_enable, 1'b0);
			check("limit analog", analog_error, k ? 1'b0 : 1'b1);
			set_v <= 16'h0064;
			settle();
			status_is(k ? 32'h10 : 32'h04);
			apb(1'b1, OFS_ACK, 32'h3F);
			settle();
			check("limit back", dc_input_enable, 1'b1);
		end
		// Sharing link: mode off with cable, then the cable removed and acknowledged.
		apb(1'b1, OFS_CTRL, 32'h00000601);
		cable <= 1'b1;
		settle();
		cnt[5]++;
		check("sf off", dc_input_enable, 1'b0);
		cable <= 1'b0;
		settle();
		apb(1'b1, OFS_ACK, 32'h3F);
		status_is(0);
		// Master: quiet without cable, then a slave fault, then a cable break.
		apb(1'b1, OFS_CTRL, 32'h00000629);
		settle();
		status_is(0);
		slave_fail <= 1'b1;
		settle();
		cnt[5]++;
		check("ms slave", dc_input_enable, 1'b0);
		slave_fail <= 1'b0;
		cable <= 1'b1;
		settle();
		apb(1'b1, OFS_ACK, 32'h3F);
		settle();
		check("ms run", dc_input_enable, 1'b1);
		cable <= 1'b0;
		settle();
		cnt[5]++;
		status_is(32'h20);
		check("ms break", dc_input_enable, 1'b0);
		apb(1'b1, OFS_CTRL, 32'h00000601);
		apb(1'b1, OFS_ACK, 32'h3F);
		status_is(0);
		apb(1'b1, OFS_CTRL, 32'h00000611);
		settle();
		cnt[5]++;
		apb(1'b1, OFS_ACK, 32'h3F);
		status_is(32'h20);
		check("sf report", share_fail_report, 1'b1);
		check("sf block", dc_input_enable, 1'b0);
		// Slave with the link back, then initialized only after boot.
		cable <= 1'b1;
		settle();
		apb(1'b1, OFS_ACK, 32'h3F);
		status_is(0);
		apb(1'b1, OFS_CTRL, 32'h00000631);
		settle();
		cnt[5]++;
		apb(1'b1, OFS_ACK, 32'h3F);
		status_is(32'h20);
		for (int i = 0; i < 6; i++) rdchk("count", 12'(OFS_COUNT_BASE + 4 * i), cnt[i]);
		give_verdict();
	end
endmodule // load_alarm_supervisor_tb
